/* File: include/nec_map.vh */
// Register map, field positions and timing counts of the NAND ECC engine
// How it works
// - Compare regs: lane one [7:0], two [23:16]
// - 1-bit mode accumulates every unlocked byte
// - Control bits 5/4 clear main/spare parity
// - Main freeze bit 7 holds main parity
// - Spare freeze bit 6 holds spare parity
// - Unlocked bytes update main results 0/1
// - Unlocked bytes update spare result register
// - Error status 0 compares generated and stored
// - Message size 0 is 512, 1 is 24
// - 4-bit code loads into results 0/1
// - Code carries protection byte over itself
// - Reading stored parity starts error search
// - 4-bit search 155 cycles, reads continue
// - Status bit 6 flags search complete
// - Error status and pattern describe errors
// - 8-bit code loads four parity registers
// - 1-bit parity per byte lane, 2048 bytes
// - 8-bit search 372 cycles, same done bit
`ifndef NEC_MAP_VH
`define NEC_MAP_VH
`define NEC_OFF_CONF 8'h00
`define NEC_OFF_CONT 8'h04
`define NEC_OFF_MCMP0 8'h14
`define NEC_OFF_MCMP1 8'h18
`define NEC_OFF_SCMP 8'h1C
`define NEC_OFF_STAT 8'h28
`define NEC_OFF_ERR0 8'h2C
`define NEC_OFF_ERR1 8'h30
`define NEC_OFF_MRES0 8'h34
`define NEC_OFF_MRES1 8'h38
`define NEC_OFF_SRES 8'h3C
`define NEC_OFF_PAT 8'h40
`define NEC_OFF_EP0 8'h50
`define NEC_OFF_EP1 8'h54
`define NEC_OFF_EP2 8'h58
`define NEC_OFF_EP3 8'h5C
`define NEC_MAIN_FRZ 7
`define NEC_SPR_FRZ 6
`define NEC_MAIN_CLR 5
`define NEC_SPR_CLR 4
`define NEC_MSGSZ 25
`define NEC_CODE_HI 24
`define NEC_CODE_LO 23
`define NEC_DONE_BIT 6
`define NEC_FRZ_RST 1'h1
`define NEC_MODE_1BIT 2'h0
`define NEC_MODE_8BIT 2'h1
`define NEC_MODE_4BIT 2'h2
`define NEC_LEN_LONG 10'h200
`define NEC_LEN_SHORT 10'h018
`define NEC_PBYTES_4 4'h8
`define NEC_PBYTES_8 4'hD
`define NEC_SRCH_4 9'h09B
`define NEC_SRCH_8 9'h174
`define NEC_LANE_A 0
`define NEC_LANE_B 16
`endif

/* File: src/nec_lane_par.v */
// One byte lane of 1-bit column and line parity accumulation
`timescale 1ns/1ps
module nec_lane_par #(
  parameter IDX_W = 11
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Control
  input wire clr_i,
  input wire en_i,
  input wire [7:0] byte_i,
  // Code
  output wire [7:0] code_o
);
  reg [5:0] col_r;
  reg lpe_r;
  reg lpo_r;
  reg [IDX_W-1:0] idx_r;
  wire [5:0] col_nxt;

  // Column pairs for bit groups of 4, 2 and 1
  assign col_nxt[5] = ^byte_i[7:4];
  assign col_nxt[4] = ^byte_i[3:0];
  assign col_nxt[3] = ^{byte_i[7:6], byte_i[3:2]};
  assign col_nxt[2] = ^{byte_i[5:4], byte_i[1:0]};
  assign col_nxt[1] = ^{byte_i[7], byte_i[5], byte_i[3], byte_i[1]};
  assign col_nxt[0] = ^{byte_i[6], byte_i[4], byte_i[2], byte_i[0]};
  assign code_o = {col_r, lpo_r, lpe_r};

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      col_r <= 6'h00;
      lpe_r <= 1'b0;
      lpo_r <= 1'b0;
      idx_r <= {IDX_W{1'b0}};
    end
    else if (clr_i)
    begin
      col_r <= 6'h00;
      lpe_r <= 1'b0;
      lpo_r <= 1'b0;
      idx_r <= {IDX_W{1'b0}};
    end
    else if (en_i)
    begin
      col_r <= col_r ^ col_nxt;
      if (idx_r[0])
        lpo_r <= lpo_r ^ (^byte_i);
      else
        lpe_r <= lpe_r ^ (^byte_i);
      idx_r <= idx_r + {{(IDX_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // nec_lane_par

/* File: src/nec_engine.v */
// NAND ECC engine: 1-bit lane parity, 4/8-bit code generation and error search
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "nec_map.vh"
module nec_engine #(
  parameter [95:0] POLY = 96'h0000_0000_0000_0000_0000_0087,
  parameter IDX_W = 11
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wr_data_i,
  input wire wr_stb_i,
  input wire rd_stb_i,
  output reg [31:0] rd_data_o,
  // Flash byte stream
  input wire byte_stb_i,
  input wire [7:0] byte_i,
  input wire [1:0] byte_lane_i,
  input wire byte_rd_i,
  // Status
  output wire decode_done_o
);
  localparam [3:0] ST_MSG = 4'b0001;
  localparam [3:0] ST_PAR = 4'b0010;
  localparam [3:0] ST_SRCH = 4'b0100;
  localparam [3:0] ST_IDLE = 4'b1000;

  reg [1:0] code_strength_select_r;
  reg message_size_select_r;
  reg main_parity_freeze_r;
  reg spare_parity_freeze_r;
  reg [15:0] mcmp0_r;
  reg [15:0] mcmp1_r;
  reg [15:0] scmp_r;
  reg [3:0] state_r;
  reg [95:0] crc_r;
  reg [103:0] gen_r;
  reg [103:0] stored_r;
  reg [9:0] mcnt_r;
  reg [3:0] pcnt_r;
  reg [8:0] scnt_r;
  reg done_r;
  reg [31:0] rd_nxt;

  wire wr_cont = wr_stb_i && (addr_i == `NEC_OFF_CONT);
  wire main_clr = wr_cont && wr_data_i[`NEC_MAIN_CLR];
  wire spr_clr = wr_cont && wr_data_i[`NEC_SPR_CLR];
  wire mode_1b = (code_strength_select_r == `NEC_MODE_1BIT);
  wire mode_8b = (code_strength_select_r == `NEC_MODE_8BIT);
  wire mode_4b = (code_strength_select_r == `NEC_MODE_4BIT);
  wire multi = mode_4b || mode_8b;
  wire [9:0] msg_len = message_size_select_r ? `NEC_LEN_SHORT : `NEC_LEN_LONG;
  wire [3:0] par_len = mode_8b ? `NEC_PBYTES_8 : `NEC_PBYTES_4;
  wire [8:0] srch_len = mode_8b ? `NEC_SRCH_8 : `NEC_SRCH_4;
  wire take_main = byte_stb_i && !main_parity_freeze_r;
  wire take_spare = byte_stb_i && !spare_parity_freeze_r;
  // Last message byte, last parity byte and last search cycle
  wire msg_last = (mcnt_r + 10'h001 == msg_len);
  wire par_last = (pcnt_r + 4'h1 == par_len);
  wire srch_last = (scnt_r + 9'h001 == srch_len);
  wire [95:0] crc_nxt = crc_step(crc_r, byte_i, mode_8b);
  wire [47:0] lane_code;
  wire [103:0] syn = gen_r ^ stored_r;
  wire [31:0] lane_syn = {lane_code[31:24] ^ mcmp1_r[15:8], lane_code[23:16] ^ mcmp1_r[7:0],
                          lane_code[15:8] ^ mcmp0_r[15:8], lane_code[7:0] ^ mcmp0_r[7:0]};
  wire [15:0] spr_syn = {lane_code[47:40] ^ scmp_r[15:8], lane_code[39:32] ^ scmp_r[7:0]};
  reg [31:0] err0;
  reg [31:0] err1;

  // Serial code step; 4-bit mode keeps a 56-bit remainder
  function [95:0] crc_step;
    input [95:0] c;
    input [7:0] b;
    input w8;
    integer i;
    reg fb;
    begin
      crc_step = c;
      for (i = 7; i >= 0; i = i - 1)
      begin
        fb = (w8 ? crc_step[95] : crc_step[55]) ^ b[i];
        crc_step = {crc_step[94:0], 1'b0} ^ (fb ? POLY : 96'h0);
      end
      if (!w8)
        crc_step[95:56] = 40'h0;
    end
  endfunction

  // Protection byte folded over the code bits
  function [7:0] fold8;
    input [95:0] c;
    integer i;
    begin
      fold8 = 8'h00;
      for (i = 0; i < 12; i = i + 1)
        fold8 = fold8 ^ c[i*8 +: 8];
    end
  endfunction

  // Compare register lanes as 32-bit words
  function [31:0] lanes32;
    input [15:0] v;
    begin
      lanes32 = {8'h00, v[15:8], 8'h00, v[7:0]};
    end
  endfunction

  // Four main-area lanes, one per byte of the data word
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : main_lane
      wire en;
      assign en = mode_1b && take_main && ({30'h0, byte_lane_i} == g);
      nec_lane_par #(
        .IDX_W(IDX_W)
      ) nec_lane_par_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(main_clr),
        .en_i(en),
        .byte_i(byte_i),
        .code_o(lane_code[g*8 +: 8])
      );
    end
    // Two spare-area lanes, picked by the low lane bit
    for (g = 0; g < 2; g = g + 1)
    begin : spare_lane
      wire en;
      assign en = take_spare && ({31'h0, byte_lane_i[0]} == g);
      nec_lane_par #(
        .IDX_W(IDX_W)
      ) nec_lane_par_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(spr_clr),
        .en_i(en),
        .byte_i(byte_i),
        .code_o(lane_code[32 + g*8 +: 8])
      );
    end
  endgenerate

  // Error flags: lane mismatches in 1-bit mode, search result otherwise
  always @*
  begin
    err0 = 32'h0;
    err1 = 32'h0;
    if (mode_1b)
    begin
      err0[3:0] = {|lane_syn[31:24], |lane_syn[23:16], |lane_syn[15:8], |lane_syn[7:0]};
      err0[5:4] = {|spr_syn[15:8], |spr_syn[7:0]};
      err1 = lane_syn;
    end
    else if (done_r)
    begin
      err0[0] = |syn;
      err1 = syn[31:0];
    end
  end
  assign decode_done_o = done_r;

  // Software registers
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      code_strength_select_r <= `NEC_MODE_1BIT;
      message_size_select_r <= 1'b0;
      main_parity_freeze_r <= `NEC_FRZ_RST;
      spare_parity_freeze_r <= `NEC_FRZ_RST;
      mcmp0_r <= 16'h0000;
      mcmp1_r <= 16'h0000;
      scmp_r <= 16'h0000;
    end
    else if (wr_stb_i)
    begin
      case (addr_i)
        `NEC_OFF_CONF:
        begin
          code_strength_select_r <= wr_data_i[`NEC_CODE_HI:`NEC_CODE_LO];
          message_size_select_r <= wr_data_i[`NEC_MSGSZ];
        end
        `NEC_OFF_CONT:
        begin
          main_parity_freeze_r <= wr_data_i[`NEC_MAIN_FRZ];
          spare_parity_freeze_r <= wr_data_i[`NEC_SPR_FRZ];
        end
        `NEC_OFF_MCMP0: mcmp0_r <= {wr_data_i[`NEC_LANE_B +: 8], wr_data_i[`NEC_LANE_A +: 8]};
        `NEC_OFF_MCMP1: mcmp1_r <= {wr_data_i[`NEC_LANE_B +: 8], wr_data_i[`NEC_LANE_A +: 8]};
        `NEC_OFF_SCMP: scmp_r <= {wr_data_i[`NEC_LANE_B +: 8], wr_data_i[`NEC_LANE_A +: 8]};
        default: ;
      endcase
    end
  end

  // Multi-bit encoder, parity capture and error search
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_MSG;
      crc_r <= 96'h0;
      gen_r <= 104'h0;
      stored_r <= 104'h0;
      mcnt_r <= 10'h000;
      pcnt_r <= 4'h0;
      scnt_r <= 9'h000;
      done_r <= 1'b0;
    end
    // Clear restarts the engine, even mid-search
    else if (main_clr)
    begin
      state_r <= ST_MSG;
      crc_r <= 96'h0;
      stored_r <= 104'h0;
      mcnt_r <= 10'h000;
      pcnt_r <= 4'h0;
      scnt_r <= 9'h000;
      done_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_MSG:
        begin
          if (multi && take_main)
          begin
            crc_r <= crc_nxt;
            mcnt_r <= mcnt_r + 10'h001;
            if (msg_last)
            begin
              if (mode_8b)
                gen_r <= {fold8(crc_nxt), crc_nxt};
              else
                gen_r <= {40'h0, fold8(crc_nxt), crc_nxt[55:0]};
              pcnt_r <= 4'h0;
              state_r <= byte_rd_i ? ST_PAR : ST_IDLE;
            end
          end
        end
        ST_PAR:
        begin
          if (byte_stb_i && byte_rd_i)
          begin
            stored_r[pcnt_r*8 +: 8] <= byte_i;
            pcnt_r <= pcnt_r + 4'h1;
            if (par_last)
            begin
              scnt_r <= 9'h000;
              state_r <= ST_SRCH;
            end
          end
        end
        ST_SRCH:
        begin
          scnt_r <= scnt_r + 9'h001;
          if (srch_last)
          begin
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: ;
        default: state_r <= ST_MSG;
      endcase
    end
  end

  // Read mux, data valid only in the cycle after the strobe
  always @*
  begin
    rd_nxt = 32'h0;
    case (addr_i)
      `NEC_OFF_CONF: rd_nxt = {6'h0, message_size_select_r, code_strength_select_r, 23'h0};
      `NEC_OFF_CONT: rd_nxt = {24'h0, main_parity_freeze_r, spare_parity_freeze_r, 6'h0};
      `NEC_OFF_MCMP0: rd_nxt = lanes32(mcmp0_r);
      `NEC_OFF_MCMP1: rd_nxt = lanes32(mcmp1_r);
      `NEC_OFF_SCMP: rd_nxt = lanes32(scmp_r);
      `NEC_OFF_STAT: rd_nxt = {25'h0, done_r, 6'h0};
      `NEC_OFF_ERR0: rd_nxt = err0;
      `NEC_OFF_ERR1: rd_nxt = err1;
      `NEC_OFF_MRES0: rd_nxt = mode_1b ? lanes32(lane_code[15:0]) : gen_r[31:0];
      `NEC_OFF_MRES1: rd_nxt = mode_1b ? lanes32(lane_code[31:16]) : gen_r[63:32];
      `NEC_OFF_SRES: rd_nxt = lanes32(lane_code[47:32]);
      `NEC_OFF_PAT: rd_nxt = (done_r && multi) ? syn[63:32] : 32'h0;
      `NEC_OFF_EP0: rd_nxt = gen_r[31:0];
      `NEC_OFF_EP1: rd_nxt = gen_r[63:32];
      `NEC_OFF_EP2: rd_nxt = gen_r[95:64];
      `NEC_OFF_EP3: rd_nxt = {24'h0, gen_r[103:96]};
      default: rd_nxt = 32'h0;
    endcase
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rd_data_o <= 32'h0;
    else
      rd_data_o <= rd_stb_i ? rd_nxt : 32'h0;
  end
endmodule // nec_engine

/* File: tb/nec_engine_props.sv */
// Port assertions for the NAND ECC engine
`timescale 1ns/1ps
module nec_engine_props #(
  parameter IDX_W = 11
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wr_data_i,
  input wire wr_stb_i,
  input wire rd_stb_i,
  input wire [31:0] rd_data_o,
  // Stream and status
  input wire byte_stb_i,
  input wire decode_done_o
);
  reg [8:0] since_r;
  wire clr_w = wr_stb_i && addr_i == 8'h04 && wr_data_i[5];
  // Cycles since the last flash byte
  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
      since_r <= 9'h000;
    else if (byte_stb_i)
      since_r <= 9'h000;
    else if (since_r != 9'h1FF)
      since_r <= since_r + 9'h001;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rd_idle_zero: assert property (!rd_stb_i |=> rd_data_o == 32'h0) else $error("read data not zero");
  a_clr_drops_done: assert property (clr_w |=> !decode_done_o) else $error("done kept over clear");
  a_clr_reads_zero: assert property (rd_stb_i && addr_i == 8'h04 |=> rd_data_o[5:4] == 2'h0)
    else $error("clear bits read nonzero");
  a_status_done: assert property (rd_stb_i && addr_i == 8'h28 |=> rd_data_o[6] == $past(decode_done_o))
    else $error("status done differs");
  a_search_min: assert property ($rose(decode_done_o) |-> since_r >= 9'h09B) else $error("search too short");
  a_unmapped_zero: assert property (rd_stb_i && addr_i == 8'h08 |=> rd_data_o == 32'h0) else $error("unmapped read");
  a_main_cmp_bytes: assert property (rd_stb_i && (addr_i == 8'h14 || addr_i == 8'h18) |=>
    rd_data_o[31:24] == 8'h00 && rd_data_o[15:8] == 8'h00) else $error("main compare unused bytes");
  a_spare_cmp_bytes: assert property (rd_stb_i && addr_i == 8'h1C |=>
    rd_data_o[31:24] == 8'h00 && rd_data_o[15:8] == 8'h00) else $error("spare compare unused bytes");
  c_done: cover property ($rose(decode_done_o));
  c_clear: cover property (clr_w);
  c_stat: cover property (rd_stb_i && addr_i == 8'h28 ##1 rd_data_o[6]);
endmodule // nec_engine_props
bind nec_engine nec_engine_props #(.IDX_W(IDX_W)) nec_engine_props_i (.clk_i(clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o),
  .byte_stb_i(byte_stb_i), .decode_done_o(decode_done_o));

/* File: tb/nec_flash_model.sv */
// Flash-side byte stream model
`timescale 1ns/1ps
module nec_flash_model (
  // Clock
  input wire clk_i,
  // Byte stream
  output logic byte_stb_o,
  output logic [7:0] byte_o,
  output logic [1:0] byte_lane_o,
  output logic byte_rd_o
);
  initial
  begin
    byte_stb_o = 1'b0;
    byte_o = 8'h00;
    byte_lane_o = 2'h0;
    byte_rd_o = 1'b1;
  end
  // Counting bytes from b; gap idle cycles after each
  task automatic send(input logic [7:0] b, input logic [1:0] ln, input logic rd, input int n, input int gap);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      byte_stb_o <= 1'b1;
      byte_o <= b + i[7:0];
      byte_lane_o <= ln;
      byte_rd_o <= rd;
      if (gap > 0)
      begin
        @(posedge clk_i);
        byte_stb_o <= 1'b0;
        byte_o <= ~byte_o;
        repeat (gap - 1) @(posedge clk_i);
      end
    end
    @(posedge clk_i);
    byte_stb_o <= 1'b0;
    byte_o <= ~byte_o;
  endtask
endmodule // nec_flash_model

/* File: tb/nec_engine_tb.sv */
// Self-checking bench for the NAND ECC engine
`timescale 1ns/1ps
module nec_engine_tb;
  logic clk_i, rst_i, wr_stb_i, rd_stb_i, byte_stb_i, byte_rd_i, decode_done_o;
  logic [7:0] addr_i, byte_i;
  logic [31:0] wr_data_i, rd_data_o, d, m, m2, s, e;
  logic [127:0] par;
  logic [1:0] byte_lane_i;
  int bad_count = 0;
  int num_checks = 0;
  nec_engine nec_engine_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o), .byte_stb_i(byte_stb_i), .byte_i(byte_i),
    .byte_lane_i(byte_lane_i), .byte_rd_i(byte_rd_i), .decode_done_o(decode_done_o));
  nec_flash_model nec_flash_model_i (.clk_i(clk_i), .byte_stb_o(byte_stb_i), .byte_o(byte_i),
    .byte_lane_o(byte_lane_i), .byte_rd_o(byte_rd_i));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    wr_stb_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= v;
    @(posedge clk_i);
    wr_stb_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    rd_stb_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_stb_i <= 1'b0;
    #1 v = rd_data_o;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Multi-bit decode: message, stored parity (first byte xor flip), then search
  task automatic run_dec(input logic [31:0] cfg, input int n, input logic [7:0] ra, input int np, input int tmin,
    input logic [7:0] flip);
    logic [7:0] x;
    int i;
    int cnt;
    wr(8'h00, cfg);
    wr(8'h04, 32'h0000_0040);
    wr(8'h04, 32'h0000_0060);
    nec_flash_model_i.send(8'h11, 2'h0, 1'b1, n, 0);
    for (i = 0; i < 4; i++)
    begin
      rd(ra + {i[5:0], 2'b00}, d);
      par[32 * i +: 32] = d;
    end
    chk("code_loaded", |par, 1'b1);
    x = 8'h00;
    for (i = 0; i < np - 1; i++)
      x = x ^ par[8 * i +: 8];
    chk("prot_byte", par[8 * (np - 1) +: 8], x);
    for (i = 0; i < np; i++)
      nec_flash_model_i.send(par[8 * i +: 8] ^ (i == 0 ? flip : 8'h00), 2'h0, 1'b1, 1, 0);
    cnt = 0;
    while (decode_done_o !== 1'b1 && cnt < 1000)
    begin
      @(negedge clk_i);
      cnt++;
    end
    chk("search_len", cnt >= tmin, 1'b1);
    chk("done_out", decode_done_o, 1'b1);
    rd(8'h28, d);
    chk("status_done", d[6], 1'b1);
    rd(8'h2C, d);
    chk("err_flag", d[0], flip != 8'h00);
    rd(8'h30, d);
    chk("err_syn", d, {24'h0, flip});
    rd(8'h40, d);
    chk("err_pat", d, 32'h0);
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    stop_test;
  end
  initial
  begin
    rst_i = 1'b1;
    {wr_stb_i, rd_stb_i, addr_i, wr_data_i} = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h04, d);
    chk("ctrl_reset", d[7:4], 4'hC);
    rd(8'h08, d);
    chk("unmapped", d, 32'h0);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, d);
    chk("main_cmp", d, 32'h00FF_00FF);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, d);
    chk("spare_cmp", d, 32'h00FF_00FF);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0000_0030);
    rd(8'h04, d);
    chk("ctrl_clear", d[7:4], 4'h0);
    nec_flash_model_i.send(8'h01, 2'h0, 1'b0, 5, 2);
    nec_flash_model_i.send(8'h21, 2'h1, 1'b1, 3, 0);
    rd(8'h34, m);
    rd(8'h38, m2);
    rd(8'h3C, s);
    chk("main_upd", |m, 1'b1);
    chk("spare_upd", |s, 1'b1);
    wr(8'h04, 32'h0000_00C0);
    nec_flash_model_i.send(8'h5A, 2'h0, 1'b1, 4, 0);
    rd(8'h34, d);
    chk("main_frozen", d, m);
    rd(8'h3C, d);
    chk("spare_frozen", d, s);
    wr(8'h14, m);
    wr(8'h18, m2);
    wr(8'h1C, s);
    rd(8'h2C, d);
    chk("err_none", d[5:0], 6'h00);
    wr(8'h14, m ^ 32'h1);
    rd(8'h2C, d);
    chk("err_lane0", d[0], 1'b1);
    rd(8'h30, d);
    chk("err1_lane0", d, 32'h0000_0001);
    run_dec(32'h0300_0000, 24, 8'h34, 8, 155, 8'h00);
    run_dec(32'h0300_0000, 24, 8'h34, 8, 155, 8'h04);
    run_dec(32'h0100_0000, 512, 8'h34, 8, 155, 8'h00);
    wr(8'h00, 32'h0280_0000);
    wr(8'h04, 32'h0000_0040);
    wr(8'h04, 32'h0000_0060);
    nec_flash_model_i.send(8'h11, 2'h0, 1'b0, 24, 0);
    rd(8'h50, e);
    chk("enc_no_search", decode_done_o, 1'b0);
    run_dec(32'h0280_0000, 24, 8'h50, 13, 372, 8'h10);
    chk("enc_code", e, par[31:0]);
    stop_test;
  end
endmodule // nec_engine_tb
